//--- verif/adc_rx_latch.sv
// receiving logic that latches both channels' output words
// assumes chan outputs are registered on clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "adc_out_defines.svh"

module adc_rx_latch
  import adc_out_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire chan_out_t          chan_a,
  input  wire chan_out_t          chan_b,
  output logic      [`WORD_W-1:0] held_a,
  output logic      [`WORD_W-1:0] held_b
);
  // drop invalid words
  // words during recovery or with the bus released are never taken
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      held_a <= '0;
      held_b <= '0;
    end else begin
      if (chan_a.oe && chan_a.valid) held_a <= chan_a.data;
      if (chan_b.oe && chan_b.valid) held_b <= chan_b.data;
    end
  end
endmodule : adc_rx_latch
`default_nettype wire

//--- verif/dual_adc_output_control_tb.sv
// self-checking bench of the dual converter output control
// encode runs 3 high, 3 low clk_sys: above the minimum rate, below max
`timescale 1ns/1ps
`default_nettype none
`include "adc_out_defines.svh"

module dual_adc_output_control_tb
  import adc_out_pkg::*;
;
  logic      clk_sys = 1'b0;
  logic      rst = 1'b1;
  apb_req_t  apb_req = '0;
  apb_rsp_t  apb_rsp;
  logic      encode_a = 1'b0;
  logic      encode_b = 1'b0;
  logic [9:0] sample_a = '0;
  logic [9:0] sample_b = '0;
  logic      output_format_select = 1'b0;
  logic      mode_select_first = 1'b0;
  logic      mode_select_second = 1'b0;
  chan_out_t chan_a;
  chan_out_t chan_b;
  logic [9:0] held_a;
  logic [9:0] held_b;
  int        n_errors = 0;
  int        checked = 0;
  int        cyc = 0;
  int        na = 0;
  int        nb = 0;
  logic      pd_a = 1'b0;
  logic      pd_b = 1'b0;
  logic      aln = 1'b0;
  logic      anti = 1'b0;
  logic [9:0] ha[$];
  logic [9:0] hb[$];
  logic [9:0] eb = '0;
  logic [31:0] rd;
  logic      err;

  always #4 clk_sys = ~clk_sys;

  dual_adc_output_control i_dual_adc_output_control (
    .clk_sys(clk_sys), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .encode_a(encode_a), .encode_b(encode_b),
    .sample_a(sample_a), .sample_b(sample_b),
    .output_format_select(output_format_select),
    .mode_select_first(mode_select_first),
    .mode_select_second(mode_select_second),
    .chan_a(chan_a), .chan_b(chan_b));

  adc_rx_latch i_adc_rx_latch (
    .clk_sys(clk_sys), .rst(rst), .chan_a(chan_a), .chan_b(chan_b),
    .held_a(held_a), .held_b(held_b));

  task summarize;
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  task chk(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // raw samples are offset binary; twos complement flips the top bit
  function automatic logic [9:0] fw(input logic [9:0] w);
    return output_format_select ? {~w[9], w[8:0]} : w;
  endfunction : fw

  // word due now: the one sampled five encode rises ago
  function automatic logic [9:0] old5(input logic [9:0] q[$]);
    return q.size() > 5 ? q[q.size()-6] : 10'h000;
  endfunction : old5

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    do @(posedge clk_sys); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : apb

  // six-cycle encode period
  // starts on the edge the caller stopped at; samples held all period
  task step(input logic [9:0] sa, input logic [9:0] sb);
    logic [9:0] nw;
    logic [9:0] xa;
    logic [9:0] xb;
    encode_a <= 1'b1;
    encode_b <= ~anti;
    sample_a <= sa;
    sample_b <= sb;
    if (!pd_a) begin ha.push_back(sa); na++; end
    if (!pd_b) begin hb.push_back(sb); nb++; end
    repeat (3) @(posedge clk_sys);
    // format pin has settled by now, as the design sees it
    nw = fw(old5(hb));
    xa = fw(old5(ha));
    xb = (!anti && !aln) ? nw : eb;
    if (!pd_a) chk(chan_a.data, xa);
    if (!pd_a) chk(chan_a.valid, na > 10);
    if (!pd_b) chk(chan_b.data, xb);
    eb = nw;
    encode_a <= 1'b0;
    encode_b <= anti;
    repeat (3) @(posedge clk_sys);
    if (!pd_b && !(anti && aln)) chk(chan_b.data, nw);
    if (!pd_b && !(anti && aln)) chk(chan_b.valid, nb > 10);
    chk({chan_a.oe, chan_b.oe}, {~pd_a, ~pd_b});
  endtask : step

  // pins held static
  // pins change only between encode periods, as a static strap would
  task mode(input logic f, input logic s);
    @(posedge clk_sys);
    mode_select_first <= f;
    mode_select_second <= s;
    aln = !f && s;
    pd_a = f && s;
    pd_b = f;
    if (pd_a) na = 0;
    if (pd_b) nb = 0;
    repeat (3) @(posedge clk_sys);
  endtask : mode

  task t_regs;
    apb(1'b0, `REG_CTRL, '0);
    chk({err, rd}, {1'b0, 32'h0000_00E4});
    apb(1'b0, `REG_STATUS, '0);
    chk(rd[3:0], 4'hC);
    apb(1'b0, 12'h008, '0);
    chk({err, rd}, {1'b1, 32'h0000_0000});
    apb(1'b1, `REG_STATUS, 32'h0000_0000);
    chk(err, 1'b1);
    apb(1'b1, `REG_CTRL, 32'h0000_00E7);
    pd_a = 1'b1;
    pd_b = 1'b1;
    na = 0;
    nb = 0;
    repeat (3) @(posedge clk_sys);
    chk({chan_a.oe, chan_b.oe}, 2'b00);
    apb(1'b0, `REG_STATUS, '0);
    chk(rd[3:0], 4'h3);
    apb(1'b1, `REG_CTRL, 32'h0000_00E4);
    pd_a = 1'b0;
    pd_b = 1'b0;
  endtask : t_regs

  task t_stream;
    for (int i = 0; i < 12; i++) begin
      if (i == 6) output_format_select <= 1'b1;
      step(10'(i * 37 + 5), 10'(i * 53 + 900));
    end
    mode(1'b0, 1'b1);
    for (int i = 0; i < 3; i++) step(10'(i * 91 + 17), 10'(i * 29 + 400));
    anti = 1'b1;
    for (int i = 0; i < 3; i++) step(10'(i * 71 + 3), 10'(i * 19 + 600));
  endtask : t_stream

  task t_power;
    anti = 1'b0;
    mode(1'b1, 1'b1);
    step(10'h3FF, 10'h155);
    step(10'h2AA, 10'h0F0);
    mode(1'b1, 1'b0);
    step(10'h111, 10'h222);
    step(10'h333, 10'h044);
    mode(1'b0, 1'b0);
    for (int i = 0; i < 11; i++) step(10'(i * 61 + 8), 10'(i * 43 + 77));
    chk(held_a, fw(old5(ha)));
    chk(held_b, fw(old5(hb)));
  endtask : t_power

  // hang guard: the run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_stream();
    t_power();
    summarize();
  end
endmodule : dual_adc_output_control_tb
`default_nettype wire

//--- verilog/adc_out_defines.svh
// constants of the dual converter output control block
// included by the package and by every file that uses these names;
// holds definitions and nothing else
`ifndef ADC_OUT_DEFINES_SVH
`define ADC_OUT_DEFINES_SVH

// sample word width and its top bit
`define WORD_W          10
`define WORD_MSB        9
// encode cycles from sample to delivered word
`define PIPE_DEPTH      5
`define PTR_W           3
`define PTR_LAST        3'h4
// encode cycles of invalid data after power-down release
`define RECOVER_CYCLES  4'hA
`define REC_W           4
// register bus
`define ADDR_W          12
`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
// mode table: index {first,second}; 00 normal, 01 align, 10 b off, 11 both
`define MAP_W           8
`define MAP_RESET       8'hE4

`endif

//--- verilog/adc_out_pkg.sv
// types shared by the converter output control and its delay line
// assumes the defines header sits beside it on the include path
package adc_out_pkg;
  `include "adc_out_defines.svh"

  // decoded operating modes of the two static mode pins
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_ALIGN,
    MODE_PD_B,
    MODE_PD_BOTH
  } mode_t;

  typedef struct packed {
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [`ADDR_W-1:0] paddr;
    logic [31:0]        pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  // one channel's output pins: data, output enable, data valid
  typedef struct packed {
    logic [`WORD_W-1:0] data;
    logic               oe;
    logic               valid;
  } chan_out_t;

  typedef struct packed {
    logic [15:0]       zero_hi;
    logic [`REC_W-1:0] rec_b;
    logic [`REC_W-1:0] rec_a;
    logic [1:0]        zero_lo;
    logic              valid_b;
    logic              valid_a;
    logic              oe_b;
    logic              oe_a;
    mode_t             mode;
  } status_t;

  typedef struct packed {
    logic [`PIPE_DEPTH-1:0][`WORD_W-1:0] mem;
    logic [`PTR_W-1:0]                   ptr;
    logic [`WORD_W-1:0]                  rd;
  } delay_state_t;

  typedef struct packed {
    logic               enc_a_q;
    logic               enc_b_q;
    logic               fire_a_d;
    logic               fire_b_d;
    chan_out_t          a;
    chan_out_t          b;
    logic [`WORD_W-1:0] pend_b;
    logic               pend_valid;
    logic [`REC_W-1:0]  rec_a;
    logic [`REC_W-1:0]  rec_b;
    logic [`MAP_W-1:0]  mode_map;
    logic [31:0]        rd_data;
  } ctrl_state_t;
endpackage : adc_out_pkg

//--- verilog/dual_adc_output_control.sv
// output and mode control of a dual ten-bit sampling converter
// encode clocks and samples are synchronous inputs of clk_sys; encode
// must run at most a quarter of clk_sys so edges are seen apart
`timescale 1ns/1ps
`default_nettype none
`include "adc_out_defines.svh"

module dual_adc_output_control
  import adc_out_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire apb_req_t           apb_req,
  output apb_rsp_t                apb_rsp,
  input  wire logic               encode_a,
  input  wire logic               encode_b,
  input  wire logic [`WORD_W-1:0] sample_a,
  input  wire logic [`WORD_W-1:0] sample_b,
  input  wire logic               output_format_select,
  input  wire logic               mode_select_first,
  input  wire logic               mode_select_second,
  output chan_out_t               chan_a,
  output chan_out_t               chan_b
);

  ctrl_state_t        s;
  ctrl_state_t        next_s;
  logic [`WORD_W-1:0] rd_a;
  logic [`WORD_W-1:0] rd_b;
  logic               rise_a;
  logic               rise_b;
  logic               fall_b;
  mode_t              mode;
  logic               pd_a;
  logic               pd_b;
  logic               align;
  logic               setup_ph;
  logic               access_ph;
  logic               hit_ctrl;
  logic               hit_status;
  status_t            status;

  // offset binary is native; twos complement flips the top bit
  function automatic logic [`WORD_W-1:0] fmt_word(
    input logic [`WORD_W-1:0] w,
    input logic               twos
  );
    logic [`WORD_W-1:0] r;
    r = w;
    if (twos) begin
      r[`WORD_MSB] = ~w[`WORD_MSB];
    end
    return r;
  endfunction : fmt_word

  // encode edges seen against last cycle's level
  assign rise_a = encode_a & ~s.enc_a_q;
  assign rise_b = encode_b & ~s.enc_b_q;
  assign fall_b = ~encode_b & s.enc_b_q;

  // table lookup decode
  // software may remap pin levels; the default matches the board straps
  assign mode = mode_t'(s.mode_map[{mode_select_first,
                                    mode_select_second, 1'b0} +: 2]);

  assign pd_a  = (mode == MODE_PD_BOTH);
  assign pd_b  = (mode == MODE_PD_BOTH) || (mode == MODE_PD_B);
  assign align = (mode == MODE_ALIGN);

  // five-deep delay per channel
  // a powered-down channel freezes its pipeline
  sample_delay_line u_delay_a (
    .clk_sys (clk_sys),
    .rst     (rst),
    .advance (rise_a & ~pd_a),
    .wr_data (sample_a),
    .rd_data (rd_a)
  );

  sample_delay_line u_delay_b (
    .clk_sys (clk_sys),
    .rst     (rst),
    .advance (rise_b & ~pd_b),
    .wr_data (sample_b),
    .rd_data (rd_b)
  );

  // apb decode; zero wait states, so access always completes at once
  assign setup_ph   = apb_req.psel & ~apb_req.penable;
  assign access_ph  = apb_req.psel & apb_req.penable;
  assign hit_ctrl   = (apb_req.paddr == `REG_CTRL);
  assign hit_status = (apb_req.paddr == `REG_STATUS);

  // status word shows the block's live state
  always_comb begin
    status         = '0;
    status.mode    = mode;
    status.oe_a    = s.a.oe;
    status.oe_b    = s.b.oe;
    status.valid_a = s.a.valid;
    status.valid_b = s.b.valid;
    status.rec_a   = s.rec_a;
    status.rec_b   = s.rec_b;
  end

  // next state of the whole block
  always_comb begin
    next_s          = s;
    next_s.enc_a_q  = encode_a;
    next_s.enc_b_q  = encode_b;
    next_s.fire_a_d = rise_a & ~pd_a;
    next_s.fire_b_d = rise_b & ~pd_b;

    next_s.a.oe = ~pd_a;
    next_s.b.oe = ~pd_b;

    // channel A; untouched by a B-only power-down
    // A runs alone
    if (pd_a) begin
      next_s.rec_a   = '0;
      next_s.a.valid = 1'b0;
    end else if (s.fire_a_d) begin
      next_s.a.data  = fmt_word(rd_a, output_format_select);
      next_s.a.valid = (s.rec_a == `RECOVER_CYCLES);
      if (s.rec_a != `RECOVER_CYCLES) begin
        next_s.rec_a = s.rec_a + 4'h1;
      end
    end

    // channel B
    if (pd_b) begin
      next_s.rec_b      = '0;
      next_s.b.valid    = 1'b0;
      next_s.pend_valid = 1'b0;
    end else begin
      // half period later
      // old pending word goes out before a new one is parked
      if (fall_b && align) begin
        next_s.b.data  = s.pend_b;
        next_s.b.valid = s.pend_valid;
      end
      if (s.fire_b_d) begin
        if (align) begin
          next_s.pend_b     = fmt_word(rd_b, output_format_select);
          next_s.pend_valid = (s.rec_b == `RECOVER_CYCLES);
        end else begin
          next_s.b.data  = fmt_word(rd_b, output_format_select);
          next_s.b.valid = (s.rec_b == `RECOVER_CYCLES);
        end
        if (s.rec_b != `RECOVER_CYCLES) begin
          next_s.rec_b = s.rec_b + 4'h1;
        end
      end
    end

    // read data is latched in setup so the bus sees a flip-flop
    if (setup_ph) begin
      if (hit_ctrl) begin
        next_s.rd_data = 32'(s.mode_map);
      end else if (hit_status) begin
        next_s.rd_data = status;
      end else begin
        next_s.rd_data = '0;
      end
    end

    if (access_ph && apb_req.pwrite && hit_ctrl) begin
      next_s.mode_map = apb_req.pwdata[`MAP_W-1:0];
    end
  end

  // all state in one register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s          <= '0;
      s.mode_map <= `MAP_RESET;
    end else begin
      s <= next_s;
    end
  end

  // bus answer; writes to status and any access to unmapped offsets are errors
  assign apb_rsp.prdata  = s.rd_data;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = access_ph &
                           ~(hit_ctrl | (hit_status & ~apb_req.pwrite));

  assign chan_a = s.a;
  assign chan_b = s.b;

  // power-down: buffers released, words frozen, valid dropped
  AST_PD_BOTH_HIZ: assert property (
    @(posedge clk_sys) disable iff (rst)
    mode == MODE_PD_BOTH |=> !chan_a.oe && !chan_b.oe)
    else $error("outputs still driven in full power-down");

  AST_PD_B_ONLY: assert property (
    @(posedge clk_sys) disable iff (rst)
    mode == MODE_PD_B |=> !chan_b.oe && chan_a.oe)
    else $error("b-only power-down drives the wrong buffers");

  AST_OE_A_ON: assert property (
    @(posedge clk_sys) disable iff (rst)
    !pd_a |=> chan_a.oe)
    else $error("channel a buffer off while powered");

  AST_OE_B_ON: assert property (
    @(posedge clk_sys) disable iff (rst)
    !pd_b |=> chan_b.oe)
    else $error("channel b buffer off while powered");

  AST_PD_A_HOLD: assert property (
    @(posedge clk_sys) disable iff (rst)
    pd_a |=> $stable(chan_a.data))
    else $error("channel a word moved while powered down");

  AST_PD_B_HOLD: assert property (
    @(posedge clk_sys) disable iff (rst)
    pd_b |=> $stable(chan_b.data))
    else $error("channel b word moved while powered down");

  AST_PD_A_NOT_VALID: assert property (
    @(posedge clk_sys) disable iff (rst)
    pd_a |=> !chan_a.valid)
    else $error("channel a valid while powered down");

  AST_PD_B_NOT_VALID: assert property (
    @(posedge clk_sys) disable iff (rst)
    pd_b |=> !chan_b.valid)
    else $error("channel b valid while powered down");

  // channel a keeps its latency and format when only b sleeps
  AST_A_RUNS: assert property (
    @(posedge clk_sys) disable iff (rst)
    mode == MODE_PD_B && rise_a ##1 mode == MODE_PD_B
      |=> chan_a.data == fmt_word($past(rd_a), $past(output_format_select)))
    else $error("channel a stalled during b power-down");

  // format: only the top bit differs between the two codes
  AST_TWOS: assert property (
    @(posedge clk_sys) disable iff (rst)
    s.fire_a_d && !pd_a && output_format_select
      |=> chan_a.data[`WORD_MSB] == ~$past(rd_a[`WORD_MSB]))
    else $error("twos complement top bit not inverted");

  AST_OFFSET_BIN: assert property (
    @(posedge clk_sys) disable iff (rst)
    s.fire_a_d && !pd_a && !output_format_select
      |=> chan_a.data == $past(rd_a))
    else $error("offset binary word altered");

  AST_LOW_BITS_A: assert property (
    @(posedge clk_sys) disable iff (rst)
    s.fire_a_d && !pd_a
      |=> chan_a.data[`WORD_MSB-1:0] == $past(rd_a[`WORD_MSB-1:0]))
    else $error("channel a low bits altered by format");

  // recovery: valid only once the count has run out
  AST_RECOVER: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(chan_b.valid) |-> s.rec_b == `RECOVER_CYCLES)
    else $error("channel b valid before recovery ended");

  AST_RECOVER_A: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(chan_a.valid) |-> s.rec_a == `RECOVER_CYCLES)
    else $error("channel a valid before recovery ended");

  AST_A_VALID_SET: assert property (
    @(posedge clk_sys) disable iff (rst)
    s.fire_a_d && !pd_a && s.rec_a == `RECOVER_CYCLES |=> chan_a.valid)
    else $error("channel a not valid after recovery");

  AST_RELEASE_INVALID: assert property (
    @(posedge clk_sys) disable iff (rst)
    $fell(pd_a) |-> ##1 !chan_a.valid [*2])
    else $error("channel a valid right after power-up");

  // words move only one cycle after an encode rise is seen, or at once on a b fall in align mode
  AST_A_ONLY_AFTER_FIRE: assert property (
    @(posedge clk_sys) disable iff (rst)
    !s.fire_a_d |=> $stable(chan_a.data))
    else $error("channel a word moved without an encode edge");

  AST_B_ONLY_AFTER_EDGE: assert property (
    @(posedge clk_sys) disable iff (rst)
    !s.fire_b_d && !fall_b |=> $stable(chan_b.data))
    else $error("channel b word moved without an encode edge");

  // alignment: b parks on its rise and goes out on its fall
  AST_ALIGN_HOLD: assert property (
    @(posedge clk_sys) disable iff (rst)
    s.fire_b_d && align && !fall_b && !pd_b
      |=> chan_b.data == $past(chan_b.data))
    else $error("aligned channel b changed on rising edge");

  AST_ALIGN_WAITS: assert property (
    @(posedge clk_sys) disable iff (rst)
    align && !fall_b |=> $stable(chan_b.data))
    else $error("aligned channel b moved off its falling edge");

  AST_ALIGN_FALL: assert property (
    @(posedge clk_sys) disable iff (rst)
    fall_b && align && !pd_b |=> chan_b.data == $past(s.pend_b))
    else $error("aligned channel b missed its falling edge");

  AST_SAME_EDGE: assert property (
    @(posedge clk_sys) disable iff (rst)
    s.fire_b_d && !align && !pd_b
      |=> chan_b.data == fmt_word($past(rd_b), $past(output_format_select)))
    else $error("unaligned channel b not updated on rising edge");

  // mode table changes only on an accepted control write
  AST_CTRL_WRITE: assert property (
    @(posedge clk_sys) disable iff (rst)
    access_ph && apb_req.pwrite && hit_ctrl
      |=> s.mode_map == $past(apb_req.pwdata[`MAP_W-1:0]))
    else $error("mode table write lost");

  AST_MAP_KEPT: assert property (
    @(posedge clk_sys) disable iff (rst)
    !(access_ph && apb_req.pwrite && hit_ctrl) |=> $stable(s.mode_map))
    else $error("mode table changed without a write");

endmodule : dual_adc_output_control

`default_nettype wire

//--- verilog/sample_delay_line.sv
// five-word circular delay line for one converter channel
// advance is a one-cycle strobe per encode edge; read data is registered
`timescale 1ns/1ps
`default_nettype none
`include "adc_out_defines.svh"

module sample_delay_line
  import adc_out_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               advance,
  input  wire logic [`WORD_W-1:0] wr_data,
  output logic      [`WORD_W-1:0] rd_data
);

  delay_state_t s;
  delay_state_t next_s;

  // oldest word leaves as the new one takes its slot
  always_comb begin
    next_s = s;
    if (advance) begin
      next_s.rd         = s.mem[s.ptr];
      next_s.mem[s.ptr] = wr_data;
      next_s.ptr        = (s.ptr == `PTR_LAST) ? '0 : s.ptr + 3'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data = s.rd;

  AST_PTR_WRAP: assert property (
    @(posedge clk_sys) disable iff (rst)
    advance && s.ptr == `PTR_LAST |=> s.ptr == '0)
    else $error("delay pointer did not wrap after five slots");

endmodule : sample_delay_line

`default_nettype wire
